// [dpram_host.sv]
// controller for one port of an asynchronous dual-port ram with semaphores and mailbox
// assumes the ram pins are wired directly; pin inputs are synchronised here
`include "dpram_host_defines.svh"
module dpram_host
    import dpram_host_pkg::*;
#(
    parameter int ADDR_W = `ADDR_WIDTH,
    parameter int DATA_W = `DATA_WIDTH
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              arst_n,
    // user request
    input  wire logic              req_valid,
    input  wire logic [2:0]        req_op,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   req_ready,
    // user answer
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   rsp_sem_owned,
    output logic                   rsp_busy_seen,
    output logic                   mailbox_pending,
    // ram port pins
    output logic                   mem_sel_n,
    output logic                   sem_sel_n,
    output logic                   wr_n,
    output logic                   out_en_n,
    output logic [ADDR_W-1:0]      addr,
    output logic [DATA_W-1:0]      data_o,
    output logic                   data_oe,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              busy_n,
    input  wire logic              mailbox_n
);
    typedef struct packed {
        phase_type         phase;
        op_type            op;
        logic              sem;
        logic              readback;
        logic              busy_seen;
        logic [DATA_W-1:0] din_meta;
        logic [DATA_W-1:0] din_sync;
        logic [1:0]        busy_meta;
        logic [1:0]        mbx_meta;
        logic              ready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic              owned;
        logic              busy_out;
        logic              mbx;
        logic              mem_sel_n;
        logic              sem_sel_n;
        logic              wr_n;
        logic              oe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic              doe;
    } host_state_type;

    host_state_type cur_ff;
    host_state_type nxt_cur;
    logic           tmr_load;
    logic [3:0]     tmr_count;
    logic           tmr_done;

    function automatic logic is_sem_op(input op_type o);
        return (o == op_sem_take) || (o == op_sem_release) || (o == op_sem_read);
    endfunction : is_sem_op

    pulse_timer #(
        .WIDTH (4)
    ) u_timer (
        .clock  (clock),
        .arst_n (arst_n),
        .load   (tmr_load),
        .count  (tmr_count),
        .done   (tmr_done)
    );

    always_comb begin
        nxt_cur    = cur_ff;
        tmr_load   = 1'h0;
        tmr_count  = 4'h0;
        // pin synchronisers
        nxt_cur.din_meta  = data_i;
        nxt_cur.din_sync  = cur_ff.din_meta;
        nxt_cur.busy_meta = {cur_ff.busy_meta[0], busy_n};
        nxt_cur.mbx_meta  = {cur_ff.mbx_meta[0], mailbox_n};
        nxt_cur.mbx       = ~cur_ff.mbx_meta[1];
        nxt_cur.rvalid    = 1'h0;
        case (cur_ff.phase)
            st_idle: begin
                nxt_cur.ready = 1'h1;
                if (req_valid && cur_ff.ready) begin
                    nxt_cur.ready     = 1'h0;
                    nxt_cur.op        = op_type'(req_op);
                    nxt_cur.sem       = is_sem_op(op_type'(req_op));
                    nxt_cur.readback  = (op_type'(req_op) == op_sem_take);
                    nxt_cur.busy_seen = 1'h0;
                    // address set while write strobe is high
                    nxt_cur.wr_n = 1'h1;
                    nxt_cur.addr = req_addr;
                    if (is_sem_op(op_type'(req_op))) begin
                        // only low bits select a latch
                        nxt_cur.addr = ADDR_W'(req_addr[`SEM_ADDR_BITS-1:0]);
                        nxt_cur.mem_sel_n = 1'h1;
                        nxt_cur.sem_sel_n = 1'h0;
                    end else begin
                        nxt_cur.mem_sel_n = 1'h0;
                        nxt_cur.sem_sel_n = 1'h1;
                    end
                    if (op_type'(req_op) == op_sem_take) begin
                        nxt_cur.dout = '1;
                        nxt_cur.dout[0] = `SEM_TAKE_BIT;
                    end else if (op_type'(req_op) == op_sem_release) begin
                        nxt_cur.dout = '1;
                        nxt_cur.dout[0] = `SEM_FREE_BIT;
                    end else begin
                        nxt_cur.dout = req_wdata;
                    end
                    tmr_load  = 1'h1;
                    tmr_count = 4'(`SETUP_CYC);
                    nxt_cur.phase = st_setup;
                end
            end
            st_setup: begin
                if (tmr_done) begin
                    tmr_load = 1'h1;
                    if (cur_ff.op == op_read || cur_ff.op == op_sem_read) begin
                        nxt_cur.oe_n = 1'h0;
                        nxt_cur.wr_n = 1'h1;
                        tmr_count = 4'(`READ_ACCESS_CYC + 2);
                        nxt_cur.phase = st_read;
                    end else begin
                        // drive data with output enable high so pins do not fight
                        nxt_cur.oe_n = 1'h1;
                        nxt_cur.doe  = 1'h1;
                        nxt_cur.wr_n = 1'h0;
                        tmr_count = 4'(`WRITE_PULSE_CYC);
                        nxt_cur.phase = st_write;
                    end
                end
            end
            st_write: begin
                if (!cur_ff.busy_meta[1]) begin
                    nxt_cur.busy_seen = 1'h1;
                end
                if (tmr_done) begin
                    nxt_cur.wr_n = 1'h1;
                    tmr_load  = 1'h1;
                    tmr_count = 4'(`SETUP_CYC);
                    nxt_cur.phase = st_hold;
                end
            end
            st_hold: begin
                if (tmr_done) begin
                    nxt_cur.doe = 1'h0;
                    if (cur_ff.readback) begin
                        // release select before read-back
                        nxt_cur.sem_sel_n = 1'h1;
                        tmr_load  = 1'h1;
                        tmr_count = 4'(`FLAG_UPDATE_PULSE_CYC);
                        nxt_cur.phase = st_gap;
                    end else begin
                        nxt_cur.mem_sel_n = 1'h1;
                        nxt_cur.sem_sel_n = 1'h1;
                        nxt_cur.rvalid    = 1'h1;
                        nxt_cur.busy_out  = cur_ff.busy_seen;
                        nxt_cur.phase     = st_idle;
                    end
                end
            end
            st_gap: begin
                if (tmr_done) begin
                    nxt_cur.sem_sel_n = 1'h0;
                    nxt_cur.oe_n      = 1'h0;
                    nxt_cur.wr_n      = 1'h1;
                    tmr_load  = 1'h1;
                    tmr_count = 4'(`READ_ACCESS_CYC + 2);
                    nxt_cur.phase = st_read;
                end
            end
            st_read: begin
                if (!cur_ff.busy_meta[1] && !cur_ff.sem) begin
                    nxt_cur.busy_seen = 1'h1;
                end
                if (tmr_done) begin
                    nxt_cur.oe_n      = 1'h1;
                    nxt_cur.mem_sel_n = 1'h1;
                    nxt_cur.sem_sel_n = 1'h1;
                    nxt_cur.rdata     = cur_ff.din_sync;
                    // zero on bit zero means this port holds the latch
                    nxt_cur.owned     = cur_ff.sem && !cur_ff.din_sync[0];
                    nxt_cur.busy_out  = cur_ff.busy_seen;
                    nxt_cur.rvalid    = 1'h1;
                    nxt_cur.phase     = st_idle;
                end
            end
            default: begin
                nxt_cur.phase = st_idle;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff <= '{phase: st_idle, op: op_read, mem_sel_n: 1'h1, sem_sel_n: 1'h1,
                        wr_n: 1'h1, oe_n: 1'h1, busy_meta: 2'h3, mbx_meta: 2'h3,
                        default: '0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // outputs straight from the state register
    assign req_ready       = cur_ff.ready;
    assign rsp_valid       = cur_ff.rvalid;
    assign rsp_rdata       = cur_ff.rdata;
    assign rsp_sem_owned   = cur_ff.owned;
    assign rsp_busy_seen   = cur_ff.busy_out;
    assign mailbox_pending = cur_ff.mbx;
    assign mem_sel_n       = cur_ff.mem_sel_n;
    assign sem_sel_n       = cur_ff.sem_sel_n;
    assign wr_n            = cur_ff.wr_n;
    assign out_en_n        = cur_ff.oe_n;
    assign addr            = cur_ff.addr;
    assign data_o          = cur_ff.dout;
    assign data_oe         = cur_ff.doe;
endmodule : dpram_host

// [dpram_host_defines.svh]
// timing counts and field positions for the dual-port ram port controller
// assumes a 25 MHz clock, 40 ns period
`ifndef DPRAM_HOST_DEFINES_SVH
`define DPRAM_HOST_DEFINES_SVH
`define CLK_PERIOD_NS          40
`define WRITE_PULSE_NS         40
`define WRITE_PULSE_CYC        ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACCESS_NS         80
`define READ_ACCESS_CYC        ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLAG_UPDATE_PULSE_NS   20
`define FLAG_UPDATE_PULSE_CYC  ((`FLAG_UPDATE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC              1
`define SEM_ADDR_BITS          3
`define SEM_FREE_BIT           1'h1
`define SEM_TAKE_BIT           1'h0
`define ADDR_WIDTH             14
`define DATA_WIDTH             8
`define MAILBOX_LEFT_ADDR      14'h3FFF
`define MAILBOX_RIGHT_ADDR     14'h3FFE
`endif

// [dpram_host_pkg.sv]
// types for the dual-port ram port controller
// assumes dpram_host_defines.svh is compiled alongside
package dpram_host_pkg;
    typedef enum logic [2:0] {
        op_read,
        op_write,
        op_sem_take,
        op_sem_release,
        op_sem_read
    } op_type;

    typedef enum {
        st_idle,
        st_setup,
        st_write,
        st_hold,
        st_read,
        st_gap
    } phase_type;
endpackage : dpram_host_pkg

// [pulse_timer.sv]
// down counter that reports when a loaded cycle count has run out
// assumes one clock domain and a load pulse from the same domain
module pulse_timer #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             arst_n,
    // control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    // status
    output logic                  done
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             done;
    } timer_state_type;

    timer_state_type cur_ff;
    timer_state_type nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        if (load) begin
            nxt_cur.cnt  = count;
            nxt_cur.done = 1'h0;
        end else if (cur_ff.cnt > WIDTH'(1)) begin
            nxt_cur.cnt = cur_ff.cnt - WIDTH'(1);
        end else begin
            nxt_cur.cnt  = '0;
            nxt_cur.done = 1'h1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff <= '{cnt: '0, done: 1'h1};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign done = cur_ff.done;
endmodule : pulse_timer

// [dpram_host_props.sv]
// checker: pin sequencing of the dual-port ram port controller
// assumes it is bound to dpram_host and sees only its ports
module dpram_host_props
    import dpram_host_pkg::*;
#(
    parameter int ADDR_W = 14,
    parameter int DATA_W = 8
) (
    input wire logic              clock, arst_n, req_valid, req_ready, rsp_valid,
    input wire logic [2:0]        req_op,
    input wire logic [ADDR_W-1:0] req_addr, addr,
    input wire logic [DATA_W-1:0] req_wdata, data_o,
    input wire logic              mem_sel_n, sem_sel_n, wr_n, out_en_n, data_oe
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic              take;
    logic [ADDR_W-1:0] t_addr_ff;
    logic [DATA_W-1:0] t_data_ff;
    assign take = req_valid && req_ready;
    // request captured at the take edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            t_addr_ff <= '0;
            t_data_ff <= '0;
        end else if (take) begin
            t_addr_ff <= req_addr;
            t_data_ff <= req_wdata;
        end
    end
    property p_rd_wr; !out_en_n |-> wr_n; endproperty
    a_rd_wr: assert property (p_rd_wr) else $error("write strobe low during read");
    property p_addr_hold; $changed(addr) |-> wr_n && $past(wr_n); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in pulse");
    property p_sem_no_mem; !sem_sel_n |-> mem_sel_n; endproperty
    a_sem_no_mem: assert property (p_sem_no_mem) else $error("both selects low");
    property p_take_memoff; take && req_op == 3'h2 |=> mem_sel_n [*8]; endproperty
    a_take_memoff: assert property (p_take_memoff) else $error("memory select in take");
    property p_take_zero;
        take && req_op == 3'h2 |-> ##[1:3] (!wr_n && !sem_sel_n && data_oe && !data_o[0]
            && addr[2:0] == t_addr_ff[2:0]);
    endproperty
    a_take_zero: assert property (p_take_zero) else $error("take did not write zero");
    property p_rel_one;
        take && req_op == 3'h3 |-> ##[1:3] (!wr_n && !sem_sel_n && data_oe && data_o[0]);
    endproperty
    a_rel_one: assert property (p_rel_one) else $error("release did not write one");
    property p_take_read;
        take && req_op == 3'h2 |-> ##[4:14] (!sem_sel_n && !out_en_n && wr_n);
    endproperty
    a_take_read: assert property (p_take_read) else $error("no read back after take");
    property p_wr_walk;
        take && req_op == 3'h1 |-> ##[1:3] (!wr_n && !mem_sel_n && sem_sel_n && data_oe
            && data_o == t_data_ff && addr == t_addr_ff) ##[1:4] rsp_valid;
    endproperty
    a_wr_walk: assert property (p_wr_walk) else $error("array write malformed");
endmodule : dpram_host_props
bind dpram_host dpram_host_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (.*);

// [dpram_dev_model.sv]
// model of one port of the dual-port ram; the far port acts through tasks and the oth_on and oth_addr variables
// assumes registered host pins on the same clock
module dpram_dev_model (
    input  wire logic        clock, mem_sel_n, sem_sel_n, wr_n, out_en_n, data_oe,
    input  wire logic [13:0] addr,
    input  wire logic [7:0]  data_o,
    output logic [7:0]       data_i,
    output logic             busy_n, mailbox_n, rflag_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  mem [16384];
    logic [1:0]  own [8] = '{default: 2'h0};
    logic        lflag = 0, rflag = 0, tog = 0, oth_on = 0;
    logic [13:0] oth_addr = 0;
    always @(posedge clock) tog <= ~tog;
    always @(posedge wr_n) begin
        if (!mem_sel_n) begin
            mem[addr] = data_o;
            if (addr == 14'h3FFF) rflag = 1;
        end
        if (!sem_sel_n) begin
            if (!data_o[0] && own[addr[2:0]] == 2'h0) own[addr[2:0]] = 2'h1;
            else if (data_o[0] && own[addr[2:0]] == 2'h1) own[addr[2:0]] = 2'h0;
        end
    end
    always @(negedge out_en_n) if (!mem_sel_n && addr == 14'h3FFE) lflag = 0;
    assign mailbox_n = ~lflag;
    assign rflag_n = ~rflag;
    assign busy_n = !(oth_on && !mem_sel_n && addr == oth_addr);
    assign data_i = (wr_n && !out_en_n && !data_oe) ? (!sem_sel_n ?
        {7'h7F, own[addr[2:0]] != 2'h1} : mem[addr]) : {8{tog}};
    task oth_take(input int i); if (own[i] == 2'h0) own[i] = 2'h2; endtask : oth_take
    task oth_rel(input int i); if (own[i] == 2'h2) own[i] = 2'h0; endtask : oth_rel
    task oth_mail; lflag = 1; endtask : oth_mail
endmodule : dpram_dev_model

// [dpram_host_tb.sv]
// testbench: host controller against the device model, queued expectations
// assumes the defines header and package are compiled first
`include "dpram_host_defines.svh"
module dpram_host_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dpram_host_pkg::*;
    logic clock = 0, arst_n = 0, req_valid = 0, req_ready, rsp_valid, owned, bsy, pend;
    logic mem_sel_n, sem_sel_n, wr_n, out_en_n, data_oe, busy_n, mailbox_n, rflag_n;
    logic [2:0] req_op = 0;
    logic [13:0] req_addr = 0, addr, ta [6];
    logic [7:0] req_wdata = 0, rsp_rdata, data_o, data_i, td [6];
    logic [9:0] note, q [$];
    int errors = 0, total_checks = 0, seed = 98102;
    always #20 clock = ~clock;
    dpram_host dut_u (.clock(clock), .arst_n(arst_n), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_sem_owned(owned),
        .rsp_busy_seen(bsy), .mailbox_pending(pend), .mem_sel_n(mem_sel_n),
        .sem_sel_n(sem_sel_n), .wr_n(wr_n), .out_en_n(out_en_n), .addr(addr),
        .data_o(data_o), .data_oe(data_oe), .data_i(data_i), .busy_n(busy_n),
        .mailbox_n(mailbox_n));
    dpram_dev_model dev_u (.clock(clock), .mem_sel_n(mem_sel_n), .sem_sel_n(sem_sel_n),
        .wr_n(wr_n), .out_en_n(out_en_n), .data_oe(data_oe), .addr(addr), .data_o(data_o),
        .data_i(data_i), .busy_n(busy_n), .mailbox_n(mailbox_n), .rflag_n(rflag_n));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    // one request; kind 1 data, 2 ownership, 3 busy is compared on the answer
    task automatic op(logic [2:0] o, logic [13:0] a, logic [7:0] d, logic [1:0] k,
            logic [7:0] e);
        int n;
        q.push_back({k, e});
        req_op = o;
        req_addr = a;
        req_wdata = d;
        req_valid = 1;
        for (n = 0; req_ready !== 1 && n < 30; n++) begin @(posedge clock); #1; end
        @(posedge clock);
        #1 req_valid = 0;
        for (n = 0; rsp_valid !== 1 && n < 30; n++) begin @(posedge clock); #1; end
        if (n >= 30) check(8'h00, 8'h01);
        @(posedge clock);
        #1;
    endtask : op
    always @(posedge clock) if (rsp_valid === 1) begin
        note = q.pop_front();
        if (note[9:8] == 2'h1) check(rsp_rdata, note[7:0]);
        if (note[9:8] == 2'h2) check({7'h00, owned}, note[7:0]);
        if (note[9:8] == 2'h3) check({7'h00, bsy}, note[7:0]);
    end
    initial begin
        #200000 check(8'h00, 8'h01);
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge clock);
        #1 arst_n = 1;
        @(posedge clock);
        #1 check({7'h00, pend}, 8'h00);
        for (int i = 0; i < 8; i++) op(3'h4, 14'(i), 8'h00, 2'h2, 8'h00);
        $display("test reset state done");
        ta[0] = 14'h0000;
        td[0] = 8'hFF;
        for (int i = 1; i < 6; i++) begin
            ta[i] = {1'b0, 3'(i), 10'($random(seed))};
            td[i] = 8'($random(seed));
        end
        for (int i = 0; i < 6; i++) op(3'h1, ta[i], td[i], 2'h0, 8'h00);
        for (int i = 5; i >= 0; i--) op(3'h0, ta[i], 8'h00, 2'h1, td[i]);
        $display("test array done");
        for (int i = 0; i < 8; i++) op(3'h2, 14'(i), 8'h00, 2'h2, 8'h01);
        op(3'h3, 14'h0003, 8'h01, 2'h0, 8'h00);
        op(3'h4, 14'h0003, 8'h00, 2'h2, 8'h00);
        dev_u.oth_take(3);
        op(3'h2, 14'h0003, 8'h00, 2'h2, 8'h00);
        op(3'h4, 14'h0005, 8'h00, 2'h2, 8'h01);
        dev_u.oth_rel(3);
        op(3'h2, 14'h0003, 8'h00, 2'h2, 8'h01);
        for (int i = 0; i < 8; i++) op(3'h3, 14'(i), 8'h01, 2'h0, 8'h00);
        $display("test semaphores done");
        dev_u.oth_mail();
        repeat (5) @(posedge clock);
        #1 check({7'h00, pend}, 8'h01);
        op(3'h0, `MAILBOX_RIGHT_ADDR, 8'h00, 2'h0, 8'h00);
        repeat (5) @(posedge clock);
        #1 check({7'h00, pend}, 8'h00);
        op(3'h1, `MAILBOX_LEFT_ADDR, 8'hA5, 2'h0, 8'h00);
        check({7'h00, rflag_n}, 8'h00);
        $display("test mailbox done");
        dev_u.oth_addr = 14'h0123;
        dev_u.oth_on = 1;
        op(3'h1, 14'h0123, 8'h11, 2'h3, 8'h01);
        op(3'h1, 14'h0124, 8'h22, 2'h3, 8'h00);
        dev_u.oth_on = 0;
        $display("test busy done");
        end_of_test;
    end
endmodule : dpram_host_tb
